// ---- dnconv_cfg_pkg.sv ----
// Constants and types shared by the downconverter configuration register block
// Functional notes
// - Acknowledge byte returned after every frame with address below 0x30
// - Address 0x12 loads 56-bit LO word, retunes
// - 0x13 bit 0 picks external Osc_source_pick
// - 0x14 bit 0 enables RF preamplifier
// - Attenuation byte; bits 10:8 pick attenuator
// - 0x16 bit 0 bypasses conversion path
// - 0x17 bit 0 low shunts IF output
// - 0x18 picks one of 16 bandwidths
// - 0x19 bit 0 picks upper sideband
// - 0x1A external lock and reference port direction
// - Backplane clock export only on backplane variant
// - 0x1B loads 14-bit reference trim word
// - 0x1C saves settings as startup defaults
// - 0x1D starts calibration, bit 0 picks oscillator
// - 0x1E field 1:0 sets power state
// - Auto bit 1 lets algorithm change preamp
// - Onboard compute only on query 0x30 value 13
// - Target levels are 7-bit magnitude plus sign
// - Exact byte count per register keeps framing
`default_nettype none
package dnconv_cfg_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_RF_FREQ = 8'h10;
    localparam logic [7:0] ADDR_IF_FREQ = 8'h11;
    localparam logic [7:0] ADDR_LO_TUNE = 8'h12;
    localparam logic [7:0] ADDR_OSC_SRC = 8'h13;
    localparam logic [7:0] ADDR_PREAMP = 8'h14;
    localparam logic [7:0] ADDR_ATTEN = 8'h15;
    localparam logic [7:0] ADDR_BYPASS = 8'h16;
    localparam logic [7:0] ADDR_OUT_GATE = 8'h17;
    localparam logic [7:0] ADDR_LOWPASS = 8'h18;
    localparam logic [7:0] ADDR_SIDE = 8'h19;
    localparam logic [7:0] ADDR_REFCLK = 8'h1A;
    localparam logic [7:0] ADDR_TRIM = 8'h1B;
    localparam logic [7:0] ADDR_SAVE = 8'h1C;
    localparam logic [7:0] ADDR_CAL = 8'h1D;
    localparam logic [7:0] ADDR_POWER = 8'h1E;
    localparam logic [7:0] ADDR_AUTO = 8'h1F;
    localparam logic [7:0] ADDR_QUERY = 8'h30;
    localparam logic [7:0] ADDR_SPI_OUT = 8'h34;
    localparam logic [7:0] ADDR_SPI_OUT2 = 8'h36;

    // ------------------------------------------------------------------
    // Frame lengths (last data byte index) and misc values
    // ------------------------------------------------------------------
    localparam logic [2:0] LAST_ONE = 3'h0;
    localparam logic [2:0] LAST_THREE = 3'h2;
    localparam logic [2:0] LAST_SEVEN = 3'h6;
    localparam logic [7:0] QUERY_COMPUTE = 8'h0D;
    localparam logic [7:0] ACK_VALUE = 8'h00;
    localparam logic [2:0] ATTEN_RF = 3'h0;
    localparam logic [2:0] ATTEN_IF = 3'h1;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ATT_SEL_LSB = 8;
    localparam int REF_EXPORT_BIT = 1;
    localparam int REF_DIR_BIT = 2;
    localparam int AUTO_PREAMP_BIT = 1;
    localparam int AUTO_LIN_LSB = 2;
    localparam int AUTO_HW_BIT = 5;
    localparam int IF_LVL_LSB = 8;
    localparam int MIX_LVL_LSB = 16;
    localparam int RF_LVL_LSB = 24;
    localparam int LVL_SIGN_OFS = 7;

    // Signed target level: magnitude in dB steps, sign high means negative
    typedef struct packed {
        logic neg;
        logic [6:0] mag;
    } level_t;

    // Settings driven into the RF hardware
    typedef struct packed {
        logic [55:0] lo_freq;
        logic lo_ext;
        logic preamp_on;
        logic [7:0] rf_atten;
        logic [7:0] if_atten;
        logic bypass;
        logic if_out_on;
        logic [3:0] filter_bw;
        logic upper_sb;
        logic ext_ref_lock_on;
        logic backplane_ref_export;
        logic ref_port_out;
        logic [13:0] trim_word;
        logic cal_osc_sel;
        logic [1:0] power_mode;
        logic sw_auto;
        logic auto_preamp;
        logic [2:0] linearity;
        logic onboard_calc_on;
        level_t if_lvl;
        level_t mix_lvl;
        level_t rf_lvl;
    } cfg_t;

    // One-cycle action strobes
    typedef struct packed {
        logic lo_retune;
        logic save_defaults;
        logic cal_start;
        logic auto_apply;
        logic gain_from_last;
    } evt_t;

    localparam cfg_t CFG_RST = '0;
    localparam evt_t EVT_NONE = '0;

endpackage : dnconv_cfg_pkg
`default_nettype wire

// ---- downconverter_config_regs.sv ----
// Byte-framed write-only configuration register block of the downconverter
`timescale 1ns/1ns
`default_nettype none
module downconverter_config_regs #(
    parameter bit BACKPLANE_VARIANT = 1'b1
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Incoming byte stream from the host interface
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_byte_i,
    // Preamp decision from the onboard auto-conversion engine
    input wire logic algo_preamp_we_i,
    input wire logic algo_preamp_i,
    // Acknowledge byte back to the host interface
    output logic ack_valid_o,
    output logic [7:0] ack_byte_o,
    // Settings and action strobes
    output dnconv_cfg_pkg::cfg_t cfg_o,
    output dnconv_cfg_pkg::evt_t evt_o
);
    import dnconv_cfg_pkg::*;

    // ------------------------------------------------------------------
    // Types and functions
    // ------------------------------------------------------------------

    // Frame parser states
    typedef enum logic [0:0] {
        ST_ADDR = 1'b0,
        ST_DATA = 1'b1
    } fsm_t;

    // Index of the last data byte for an address byte
    function automatic logic [2:0] last_idx(input logic [7:0] addr);
        logic [2:0] r;
        r = LAST_ONE;
        unique case (addr)
            ADDR_RF_FREQ, ADDR_IF_FREQ, ADDR_LO_TUNE: r = LAST_SEVEN;
            ADDR_AUTO, ADDR_SPI_OUT, ADDR_SPI_OUT2: r = LAST_SEVEN;
            ADDR_ATTEN, ADDR_TRIM: r = LAST_THREE;
            default: r = LAST_ONE;
        endcase
        return r;
    endfunction : last_idx

    // Place a byte into a little-endian word at the given byte index
    function automatic logic [55:0] put_byte(input logic [55:0] w,
                                             input logic [2:0] idx,
                                             input logic [7:0] b);
        logic [55:0] r;
        r = w;
        r[idx*8 +: 8] = b;
        return r;
    endfunction : put_byte

    // Pick a signed level out of the auto-conversion word
    function automatic level_t get_lvl(input logic [31:0] w, input int lsb);
        level_t r;
        r.mag = w[lsb +: 7];
        r.neg = w[lsb + LVL_SIGN_OFS];
        return r;
    endfunction : get_lvl

    // ------------------------------------------------------------------
    // Frame parser state
    // ------------------------------------------------------------------
    fsm_t state_ff; // Expecting address or data
    logic [7:0] addr_ff; // Address byte of the frame in progress
    logic [2:0] idx_ff; // Index of the next data byte
    logic [2:0] last_ff; // Index of the final data byte
    logic [55:0] data_ff; // Data bytes gathered so far
    logic [55:0] word; // Full data word including the current byte
    logic done; // Final data byte arrives this cycle
    logic take; // A byte is accepted this cycle

    assign take = ce_i && rx_valid_i;
    assign done = take && (state_ff == ST_DATA) && (idx_ff == last_ff);
    assign word = put_byte(data_ff, idx_ff, rx_byte_i);

    // Address byte opens a frame; count data bytes until its length
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_ADDR;
            addr_ff <= 8'h00;
            idx_ff <= 3'h0;
            last_ff <= 3'h0;
        end else if (take) begin
            unique case (state_ff)
                ST_ADDR: begin
                    // Every register carries at least one data byte
                    state_ff <= ST_DATA;
                    addr_ff <= rx_byte_i;
                    idx_ff <= 3'h0;
                    // Length fixed by address: 2, 4, 8 byte frames
                    last_ff <= last_idx(rx_byte_i);
                end
                ST_DATA: begin
                    if (idx_ff == last_ff) begin
                        state_ff <= ST_ADDR;
                    end else begin
                        idx_ff <= idx_ff + 3'h1;
                    end
                end
            endcase
        end
    end

    // Gather data bytes, cleared when a frame opens
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            data_ff <= 56'h0;
        end else if (take) begin
            if (state_ff == ST_ADDR) begin
                data_ff <= 56'h0;
            end else begin
                data_ff <= word;
            end
        end
    end

    // ------------------------------------------------------------------
    // Acknowledge
    // ------------------------------------------------------------------

    // One acknowledge byte after each frame whose address is below 0x30
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_valid_o <= 1'b0;
            ack_byte_o <= 8'h00;
        end else if (ce_i) begin
            ack_valid_o <= done && (addr_ff < ADDR_QUERY);
            ack_byte_o <= ACK_VALUE;
        end
    end

    // ------------------------------------------------------------------
    // Settings
    // ------------------------------------------------------------------

    // Decode finished frames; only defined fields are kept
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_o <= CFG_RST;
        end else if (ce_i) begin
            if (done) begin
                unique case (addr_ff)
                    ADDR_LO_TUNE: begin
                        cfg_o.lo_freq <= word;
                    end
                    ADDR_OSC_SRC: begin
                        cfg_o.lo_ext <= word[0];
                    end
                    ADDR_PREAMP: begin
                        cfg_o.preamp_on <= word[0];
                    end
                    ADDR_ATTEN: begin
                        // Step 0.5 dB on RF, 0.25 dB on IF
                        if (word[ATT_SEL_LSB +: 3] == ATTEN_RF) begin
                            cfg_o.rf_atten <= word[7:0];
                        end else if (word[ATT_SEL_LSB +: 3] == ATTEN_IF) begin
                            cfg_o.if_atten <= word[7:0];
                        end
                    end
                    ADDR_BYPASS: begin
                        cfg_o.bypass <= word[0];
                    end
                    ADDR_OUT_GATE: begin
                        // Low shunts the IF port to ground
                        cfg_o.if_out_on <= word[0];
                    end
                    ADDR_LOWPASS: begin
                        // 0 narrowest, 15 widest
                        cfg_o.filter_bw <= word[3:0];
                    end
                    ADDR_SIDE: begin
                        cfg_o.upper_sb <= word[0];
                    end
                    ADDR_REFCLK: begin
                        // Low keeps the internal 10 MHz reference
                        cfg_o.ext_ref_lock_on <= word[0];
                        cfg_o.ref_port_out <= word[REF_DIR_BIT];
                        // Serial variant ignores the export bit
                        cfg_o.backplane_ref_export <=
                            BACKPLANE_VARIANT && word[REF_EXPORT_BIT];
                    end
                    ADDR_TRIM: begin
                        cfg_o.trim_word <= word[13:0];
                    end
                    ADDR_CAL: begin
                        cfg_o.cal_osc_sel <= word[0];
                    end
                    ADDR_POWER: begin
                        // 0 full power, 1 synth down, 2 device down
                        cfg_o.power_mode <= word[1:0];
                    end
                    ADDR_AUTO: begin
                        cfg_o.sw_auto <= word[0];
                        cfg_o.auto_preamp <= word[AUTO_PREAMP_BIT];
                        cfg_o.linearity <= word[AUTO_LIN_LSB +: 3];
                        cfg_o.onboard_calc_on <= word[AUTO_HW_BIT];
                        cfg_o.if_lvl <= get_lvl(word[31:0], IF_LVL_LSB);
                        cfg_o.mix_lvl <= get_lvl(word[31:0], MIX_LVL_LSB);
                        cfg_o.rf_lvl <= get_lvl(word[31:0], RF_LVL_LSB);
                    end
                    default: begin
                        // Other addresses leave the settings alone
                    end
                endcase
            end else if (algo_preamp_we_i && cfg_o.auto_preamp) begin
                // Algorithm may steer the preamp only when allowed
                cfg_o.preamp_on <= algo_preamp_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Action strobes
    // ------------------------------------------------------------------

    // One-cycle strobes raised by the final byte of a frame
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            evt_o <= EVT_NONE;
        end else if (ce_i) begin
            evt_o.lo_retune <= done && (addr_ff == ADDR_LO_TUNE);
            evt_o.save_defaults <= done && (addr_ff == ADDR_SAVE);
            evt_o.cal_start <= done && (addr_ff == ADDR_CAL);
            // Query 13 applies the targets only with onboard compute on
            evt_o.auto_apply <= done && (addr_ff == ADDR_QUERY)
                && (word[7:0] == QUERY_COMPUTE) && cfg_o.onboard_calc_on;
            evt_o.gain_from_last <= done && (addr_ff == ADDR_QUERY)
                && (word[7:0] == QUERY_COMPUTE) && !cfg_o.onboard_calc_on;
        end
    end

endmodule : downconverter_config_regs
`default_nettype wire

// ---- downconverter_config_regs_props.sv ----
// Assertion checker for the configuration register block
`timescale 1ns/1ns
`default_nettype none
module dcr_props #(
    parameter bit BACKPLANE_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Inputs of the block
    input wire logic ce_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic algo_preamp_we_i,
    input wire logic algo_preamp_i,
    // Outputs of the block
    input wire logic ack_valid_o,
    input wire logic [7:0] ack_byte_o,
    input wire dnconv_cfg_pkg::cfg_t cfg_o,
    input wire dnconv_cfg_pkg::evt_t evt_o
);
    import dnconv_cfg_pkg::*;
    // ----
    // Frame tracking
    // ----
    logic [2:0] left_ff; // Bytes still due in the open frame
    logic [7:0] adr_ff; // Address of the open frame
    logic [55:0] dat_ff; // Data bytes, newest on top
    logic take; // Byte accepted this edge
    logic last; // Final byte of a frame
    logic [55:0] w56; // Word as it stands after this byte
    logic flag; // Single-bit setting picked by address
    assign take = rx_valid_i && ce_i;
    assign last = take && left_ff == 3'h1;
    assign w56 = {rx_byte_i, dat_ff[55:8]};
    // Count bytes so the frame end is known
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            left_ff <= 3'h0;
            adr_ff <= 8'h00;
        end else if (take && left_ff == 3'h0) begin
            adr_ff <= rx_byte_i;
            left_ff <= (rx_byte_i inside {8'h10, 8'h11, 8'h12, 8'h1F, 8'h34, 8'h36}) ? 3'h7 :
                (rx_byte_i inside {8'h15, 8'h1B}) ? 3'h3 : 3'h1;
        end else if (take) begin
            left_ff <= left_ff - 3'h1;
        end
    end
    // Collect data bytes, low byte first
    always_ff @(posedge clk_i) begin
        if (take) begin
            dat_ff <= w56;
        end
    end
    // Pick the flag that the open address controls
    always_comb begin
        case (adr_ff)
            ADDR_OSC_SRC: flag = cfg_o.lo_ext;
            ADDR_PREAMP: flag = cfg_o.preamp_on;
            ADDR_BYPASS: flag = cfg_o.bypass;
            ADDR_OUT_GATE: flag = cfg_o.if_out_on;
            default: flag = cfg_o.upper_sb;
        endcase
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_last(logic [7:0] a);
        last && adr_ff == a;
    endsequence
    a_ack_after_frame: assert property (last && adr_ff < ADDR_QUERY
        |=> ack_valid_o && ack_byte_o == ACK_VALUE) else $error("ack missing");
    a_ack_one_cycle: assert property (ack_valid_o && ce_i |=> !ack_valid_o)
        else $error("ack too long");
    a_query_compute: assert property (
        s_last(ADDR_QUERY) ##0 rx_byte_i == QUERY_COMPUTE
        |=> !ack_valid_o && evt_o.auto_apply == cfg_o.onboard_calc_on
        && evt_o.gain_from_last != cfg_o.onboard_calc_on) else $error("query wrong");
    a_lo_word_load: assert property (s_last(ADDR_LO_TUNE)
        |=> evt_o.lo_retune && cfg_o.lo_freq == $past(w56)) else $error("lo word wrong");
    a_flag_bits: assert property (
        last && adr_ff inside {8'h13, 8'h14, 8'h16, 8'h17, 8'h19}
        |=> flag == $past(rx_byte_i[0])) else $error("flag wrong");
    a_filter_pick: assert property (s_last(ADDR_LOWPASS)
        |=> cfg_o.filter_bw == $past(rx_byte_i[3:0])) else $error("filter wrong");
    a_refclk_bits: assert property (s_last(ADDR_REFCLK)
        |=> {cfg_o.ref_port_out, cfg_o.backplane_ref_export, cfg_o.ext_ref_lock_on}
        == ($past(rx_byte_i[2:0]) & {1'b1, BACKPLANE_VARIANT, 1'b1})) else $error("ref wrong");
    a_trim_load: assert property (s_last(ADDR_TRIM)
        |=> cfg_o.trim_word == $past(w56[45:32])) else $error("trim wrong");
    a_atten_rf: assert property (s_last(ADDR_ATTEN) ##0 w56[42:40] == ATTEN_RF
        |=> cfg_o.rf_atten == $past(w56[39:32])) else $error("atten wrong");
    a_auto_fields: assert property (s_last(ADDR_AUTO)
        |=> {cfg_o.rf_lvl, cfg_o.mix_lvl, cfg_o.if_lvl} == $past(w56[31:8])
        && {cfg_o.onboard_calc_on, cfg_o.linearity, cfg_o.auto_preamp, cfg_o.sw_auto}
        == $past(w56[5:0])) else $error("auto wrong");
    a_save_pulse: assert property (s_last(ADDR_SAVE)
        |=> evt_o.save_defaults ##1 !evt_o.save_defaults) else $error("save wrong");
    a_cal_start: assert property (s_last(ADDR_CAL)
        |=> evt_o.cal_start && cfg_o.cal_osc_sel == $past(rx_byte_i[0])) else $error("cal wrong");
    a_power_mode: assert property (s_last(ADDR_POWER) ##0 rx_byte_i[1:0] != 2'h3
        |=> cfg_o.power_mode == $past(rx_byte_i[1:0])) else $error("power wrong");
    a_algo_preamp: assert property (algo_preamp_we_i && ce_i && !last
        |=> cfg_o.preamp_on == ($past(cfg_o.auto_preamp) ? $past(algo_preamp_i)
        : $past(cfg_o.preamp_on))) else $error("algo preamp wrong");
endmodule : dcr_props
`default_nettype wire

// ---- dcr_host.sv ----
// Host model that sends register frames byte by byte
`timescale 1ns/1ns
`default_nettype none
module dcr_host (
    // Clock
    input wire logic clk_i,
    // Byte stream toward the block
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o,
    // Acknowledge from the block
    input wire logic ack_valid_i
);
    logic ack_seen; // Ack sampled after the last byte
    initial begin
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
        ack_seen = 1'b0;
    end
    // Address then n data bytes, low byte first, back to back
    task automatic send(input logic [7:0] adr, input logic [55:0] dat, input int n);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_byte_o <= adr;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            rx_byte_o <= dat[i*8 +: 8];
        end
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_byte_o <= ~rx_byte_o; // Idle line shows no stale byte
        #1;
        ack_seen = ack_valid_i;
    endtask : send
endmodule : dcr_host
`default_nettype wire

// ---- downconverter_config_regs_tb.sv ----
// Self-checking testbench of the configuration register block
`timescale 1ns/1ns
`default_nettype none
module downconverter_config_regs_tb;
    import dnconv_cfg_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic rx_valid_i;
    logic [7:0] rx_byte_i;
    logic algo_preamp_we_i = 1'b0;
    logic algo_preamp_i = 1'b0;
    logic ack_valid_o;
    logic [7:0] ack_byte_o;
    cfg_t cfg_o;
    evt_t evt_o;
    cfg_t exp; // Expected settings
    cfg_t cfg_s; // Settings of the serial variant
    int num_errors = 0;
    int comparisons = 0;
    logic [7:0] adr;
    logic [55:0] dat;
    // Corner frames: bad select, max word, auto on/off, queries, unmapped, long, ref
    logic [7:0] c_adr [13] = '{8'h15, 8'h15, 8'h12, 8'h1F, 8'h30, 8'h1F, 8'h30, 8'h30,
        8'h25, 8'h31, 8'h10, 8'h36, 8'h1A};
    logic [55:0] c_dat [13] = '{56'h0002AA, 56'h00F9FF, {56{1'b1}}, 56'hFFFFFF817F8A36,
        56'h0D, 56'h0, 56'h0D, 56'h02, 56'hA5, 56'h0, 56'h14011401140114, 56'h0, 56'h07};
    always #20 clk_i = ~clk_i;
    downconverter_config_regs DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .algo_preamp_we_i(algo_preamp_we_i),
        .algo_preamp_i(algo_preamp_i), .ack_valid_o(ack_valid_o), .ack_byte_o(ack_byte_o),
        .cfg_o(cfg_o), .evt_o(evt_o));
    // Serial variant must never export the backplane clock
    downconverter_config_regs #(.BACKPLANE_VARIANT(1'b0)) DUT_serial (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .ce_i(ce_i), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
        .algo_preamp_we_i(algo_preamp_we_i), .algo_preamp_i(algo_preamp_i),
        .ack_valid_o(), .ack_byte_o(), .cfg_o(cfg_s), .evt_o());
    dcr_host host (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i),
        .ack_valid_i(ack_valid_o));
    // Data bytes that follow an address
    function automatic int nbytes(logic [7:0] a);
        return (a inside {8'h10, 8'h11, 8'h12, 8'h1F, 8'h34, 8'h36}) ? 7
            : (a inside {8'h15, 8'h1B}) ? 3 : 1;
    endfunction : nbytes
    // Settings after a frame
    function automatic cfg_t apply(cfg_t c, logic [7:0] a, logic [55:0] d);
        case (a)
            8'h12: c.lo_freq = d;
            8'h13: c.lo_ext = d[0];
            8'h14: c.preamp_on = d[0];
            8'h15: if (d[10:8] == 3'h0) c.rf_atten = d[7:0];
                else if (d[10:8] == 3'h1) c.if_atten = d[7:0];
            8'h16: c.bypass = d[0];
            8'h17: c.if_out_on = d[0];
            8'h18: c.filter_bw = d[3:0];
            8'h19: c.upper_sb = d[0];
            8'h1A: {c.ref_port_out, c.backplane_ref_export, c.ext_ref_lock_on} = d[2:0];
            8'h1B: c.trim_word = d[13:0];
            8'h1D: c.cal_osc_sel = d[0];
            8'h1E: c.power_mode = d[1:0];
            8'h1F: {c.rf_lvl, c.mix_lvl, c.if_lvl, c.onboard_calc_on, c.linearity,
                c.auto_preamp, c.sw_auto} = {d[31:8], d[5:0]};
            default: ;
        endcase
        return c;
    endfunction : apply
    // Strobes after a frame
    function automatic evt_t evt_of(cfg_t c, logic [7:0] a, logic [55:0] d);
        evt_t e;
        logic q;
        q = a == ADDR_QUERY && d[7:0] == QUERY_COMPUTE;
        e = EVT_NONE;
        e.lo_retune = a == ADDR_LO_TUNE;
        e.save_defaults = a == ADDR_SAVE;
        e.cal_start = a == ADDR_CAL;
        e.auto_apply = q && c.onboard_calc_on;
        e.gain_from_last = q && !c.onboard_calc_on;
        return e;
    endfunction : evt_of
    task automatic cmp_cfg(input cfg_t g, input cfg_t e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_cfg
    task automatic cmp_evt(input evt_t g, input evt_t e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_evt
    task automatic cmp_bit(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_bit
    // One frame and its checks
    task automatic do_frame(input logic [7:0] a, input logic [55:0] d);
        evt_t ev;
        cfg_t es;
        ev = ce_i ? evt_of(exp, a, d) : EVT_NONE;
        if (ce_i) exp = apply(exp, a, d);
        host.send(a, d, nbytes(a));
        es = exp;
        es.backplane_ref_export = 1'b0;
        cmp_cfg(cfg_o, exp);
        cmp_cfg(cfg_s, es);
        cmp_evt(evt_o, ev);
        cmp_bit(host.ack_seen, ce_i && a < ADDR_QUERY);
    endtask : do_frame
    // Preamp request from the onboard algorithm
    task automatic algo(input logic v);
        @(posedge clk_i);
        algo_preamp_we_i <= 1'b1;
        algo_preamp_i <= v;
        @(posedge clk_i);
        algo_preamp_we_i <= 1'b0;
        #1;
        if (exp.auto_preamp) exp.preamp_on = v;
        cmp_cfg(cfg_o, exp);
    endtask : algo
    task automatic conclude();
        $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    initial begin
        void'($urandom(26866));
        exp = CFG_RST;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 13; i++) do_frame(c_adr[i], c_dat[i]);
        @(posedge clk_i) ce_i <= 1'b0;
        #1 do_frame(ADDR_PREAMP, 56'h1);
        @(posedge clk_i) ce_i <= 1'b1;
        #1;
        for (int i = 0; i < 60; i++) begin
            adr = 8'h12 + 8'($urandom_range(13));
            dat = 56'({$urandom, $urandom});
            if (adr == ADDR_POWER) dat[1:0] = 2'($urandom_range(2));
            if (adr == ADDR_AUTO) dat[4] = 1'b0;
            do_frame(adr, dat);
            algo(1'($urandom_range(1)));
        end
        conclude();
    end
    // Watchdog against a hung run
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        conclude();
    end
endmodule : downconverter_config_regs_tb
bind downconverter_config_regs dcr_props #(.BACKPLANE_VARIANT(BACKPLANE_VARIANT)) u_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .rx_valid_i(rx_valid_i),
    .rx_byte_i(rx_byte_i), .algo_preamp_we_i(algo_preamp_we_i), .algo_preamp_i(algo_preamp_i),
    .ack_valid_o(ack_valid_o), .ack_byte_o(ack_byte_o), .cfg_o(cfg_o), .evt_o(evt_o));
`default_nettype wire
